// ---- tb/mem_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module mem_side_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sequencer phase view and chosen latency
  input wire logic phase_c,
  input wire logic [3:0] delay,
  // Memory completion
  output logic mem_ref_done
);
  logic [3:0] c_cnt_reg;

  // Counts cycles spent in phase C; saturates so a slow reference never wraps to done
  always_ff @(posedge clk)
  begin
    if (!rst_n || !phase_c)
    begin
      c_cnt_reg <= 4'h0;
    end
    else if (c_cnt_reg != 4'hf)
    begin
      c_cnt_reg <= c_cnt_reg + 4'h1;
    end
  end

  // Answers at once so a zero delay gives the shortest phase C; never done outside C
  assign mem_ref_done = phase_c && (c_cnt_reg >= delay);
endmodule

`default_nettype wire

// ---- tb/microcode_cycle_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "seq_regs.svh"
`define CHK(w, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; $display("ERROR %s expected %0h seen %0h", w, e, a); end end

module microcode_cycle_sequencer_tb_top;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ustretch_req = 1'h0;
  logic ucode_instr_end = 1'h0;
  logic cache_read_miss = 1'h0;
  logic mem_ref_done;
  logic [15:0] fetch_word = 16'h0000;
  logic [3:0] cond_codes = 4'h0;
  logic [3:0] mem_delay = 4'h0;
  logic ucode_hold;
  logic prefetch_abort;
  logic pc_load;
  logic phase_a;
  logic phase_b;
  logic phase_c;
  logic cycle_end;
  logic cycle0;
  logic alu_go;
  logic alu_write_en;
  logic [3:0] alu_op;
  logic [2:0] alu_src_reg;
  logic [2:0] alu_dst_reg;
  logic [7:0] branch_disp;
  int n_errors = 0;
  int samples_checked = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  cycle_sequencer dut_u (
    .clk(clk), .rst_n(rst_n), .ustretch_req(ustretch_req), .ucode_instr_end(ucode_instr_end),
    .ucode_hold(ucode_hold), .cache_read_miss(cache_read_miss), .mem_ref_done(mem_ref_done),
    .fetch_word(fetch_word), .cond_codes(cond_codes), .prefetch_abort(prefetch_abort), .pc_load(pc_load),
    .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c), .cycle_end(cycle_end), .cycle0(cycle0),
    .alu_go(alu_go), .alu_write_en(alu_write_en), .alu_op(alu_op), .alu_src_reg(alu_src_reg),
    .alu_dst_reg(alu_dst_reg), .branch_disp(branch_disp)
  );

  mem_side_model far_u (.clk(clk), .rst_n(rst_n), .phase_c(phase_c), .delay(mem_delay), .mem_ref_done(mem_ref_done));

  task automatic at_edge;
    @(posedge clk);
  endtask

  task automatic finish_test;
    if (n_errors == 0 && samples_checked > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reset for 8 cycles, then look at the start state
  task automatic do_reset;
    at_edge;
    rst_n <= 1'h0;
    repeat (8) at_edge;
    rst_n <= 1'h1;
    // Looked at before the first edge with reset released, which already moves on to phase B
    #10;
    `CHK("phase_a cycle0", 2'h3, {phase_a, cycle0})
    `CHK("phases b c", 2'h0, {phase_b, phase_c})
    `CHK("abort load", 2'h0, {prefetch_abort, pc_load})
    `CHK("alu end", 3'h0, {alu_go, alu_write_en, cycle_end})
  endtask

  // Ends the running microcoded instruction in its phase B and hands over the next word
  task automatic load(input logic [15:0] w, input logic [3:0] cc);
    at_edge;
    ucode_instr_end <= 1'h1;
    fetch_word <= w;
    cond_codes <= cc;
    #10;
    `CHK("end of B", 2'h3, {phase_b, cycle_end})
    at_edge;
    ucode_instr_end <= 1'h0;
    fetch_word <= 16'h0000;
    #10;
    `CHK("new cycle0", 2'h3, {phase_a, cycle0})
  endtask

  // Phase C lasts until the far side completes; a hang is cut off after 20 cycles
  task automatic run_c(input logic [3:0] d, input logic br);
    int n;
    n = 0;
    while (phase_c === 1'h1 && n < 20)
    begin
      n++;
      `CHK("C end", n > d, cycle_end)
      `CHK("pc load", br && n > d, pc_load)
      `CHK("abort", br && n == 1, prefetch_abort)
      at_edge;
      #10;
    end
    if (n >= 20)
    begin
      n_errors++;
      finish_test();
    end
    `CHK("C length", d + 1, n)
    `CHK("back to A", 1'h1, phase_a)
  endtask

  // Stretch by microcode request or by cache read miss
  task automatic stretch(input logic by_ucode, input logic [3:0] d);
    at_edge;
    ustretch_req <= by_ucode;
    cache_read_miss <= !by_ucode;
    mem_delay <= d;
    #10;
    `CHK("phase B", 1'h1, phase_b)
    at_edge;
    ustretch_req <= 1'h0;
    cache_read_miss <= 1'h0;
    #10;
    `CHK("phase C", 1'h1, phase_c)
    run_c(d, 1'h0);
  endtask

  // Register op in one cycle; the next word must start right after B
  task automatic single(input logic [15:0] w);
    load(w, 4'h0);
    `CHK("hold in A", 1'h0, ucode_hold)
    at_edge;
    #10;
    `CHK("go wr hold end", 4'hf, {alu_go, alu_write_en, ucode_hold, cycle_end})
    `CHK("decode", {w[13:10], w[5:3], w[2:0]}, {alu_op, alu_src_reg, alu_dst_reg})
    at_edge;
    #10;
    `CHK("next instr", 2'h3, {phase_a, cycle0})
  endtask

  // Not-taken branches also see stretch requests, which must be ignored
  task automatic branch(input logic [15:0] w, input logic [3:0] cc, input logic tk, input logic [3:0] d);
    load(w, cc);
    at_edge;
    ustretch_req <= !tk;
    cache_read_miss <= !tk;
    mem_delay <= d;
    #10;
    `CHK("branch B", {1'h1, tk, !tk}, {alu_go, alu_write_en, cycle_end})
    `CHK("pc add", {`ALU_OP_ADD, `REG_PC, w[7:0]}, {alu_op, alu_dst_reg, branch_disp})
    at_edge;
    ustretch_req <= 1'h0;
    cache_read_miss <= 1'h0;
    #10;
    if (tk)
    begin
      `CHK("taken C", 1'h1, phase_c)
      run_c(d, 1'h1);
    end
    `CHK("next instr", 3'h5, {phase_a, phase_c, cycle0})
  endtask

  // Spare class acts as microcoded: no ALU cycle, and microcode keeps running afterwards
  task automatic spare;
    load(16'hc000, 4'h0);
    at_edge;
    #10;
    `CHK("spare B", 3'h1, {alu_go, ucode_hold, cycle_end})
    at_edge;
    #10;
    `CHK("spare next", 2'h2, {phase_a, cycle0})
  endtask

  // Reset arriving in the middle of a long phase C
  task automatic reset_in_c;
    at_edge;
    ustretch_req <= 1'h1;
    mem_delay <= 4'hf;
    at_edge;
    ustretch_req <= 1'h0;
    do_reset();
  endtask

  // Main sequence; branch words chosen so the outcome holds whatever flag the select picks
  initial
  begin
    do_reset();
    for (int k = 0; k < 4; k++)
    begin
      stretch(k[0], k[1] ? 4'h3 : 4'h0);
    end
    single(16'h4c2b);
    single(16'h7fc0);
    branch(16'ha035, 4'h0, 1'h1, 4'h2);
    branch(16'h8412, 4'h0, 1'h0, 4'h0);
    branch(16'h9012, 4'h0, 1'h1, 4'h0);
    branch(16'h8481, 4'hf, 1'h1, 4'h1);
    branch(16'h9481, 4'hf, 1'h0, 4'h0);
    reset_in_c();
    spare();
    single(16'h4c2b);
    finish_test();
  end
endmodule

`default_nettype wire

// ---- verilog/cycle_sequencer.sv ----
// Behaviour
// RULE1 - Each standard cycle is phase A then phase B, each lasting 50 ns; each phase here takes one 100 ns clock cycle.
// RULE2 - Phase C follows phase B when microcode asks for a stretch or a cache read misses; a branch's first cycle ignores both and enters C only if taken.
// RULE3 - Phase C lasts at least 50 ns and then until the memory reference completes.
// RULE4 - In the first cycle of each instruction the instruction word gives class, registers and ALU opcode.
// RULE5 - A single-cycle operation cycles the ALU while microcode holds, so the next instruction starts at once.
// RULE6 - A branch's first cycle adds PC and displacement while separate logic judges taken or not.
// RULE7 - A taken branch aborts the running prefetch and loads PC with the target during phase C.
// RULE8 - A not-taken branch suppresses write-back and ends the cycle at the close of phase B.
// RULE9 - After reset the sequencer is in phase A of a first instruction cycle with nothing pending.
`timescale 1ns/1ps
`default_nettype none
`include "seq_regs.svh"

module cycle_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Microcode store
  input wire logic ustretch_req,
  input wire logic ucode_instr_end,
  output logic ucode_hold,
  // Cache and memory
  input wire logic cache_read_miss,
  input wire logic mem_ref_done,
  // Instruction fetch and flags
  input wire logic [15:0] fetch_word,
  input wire logic [3:0] cond_codes,
  output logic prefetch_abort,
  output logic pc_load,
  // Phase timing
  output logic phase_a,
  output logic phase_b,
  output logic phase_c,
  output logic cycle_end,
  output logic cycle0,
  // ALU control
  output logic alu_go,
  output logic alu_write_en,
  output logic [3:0] alu_op,
  output logic [2:0] alu_src_reg,
  output logic [2:0] alu_dst_reg,
  output logic [7:0] branch_disp
);

  localparam logic [1:0] PHASE_LAST = 2'(`SEQ_PHASE_CYC - 1);
  localparam logic [1:0] STRETCH_LAST = 2'(`SEQ_STRETCH_MIN_CYC - 1);

  seq_pkg::seq_state_s state_reg;
  seq_pkg::seq_state_s state_next;
  logic phase_done;
  logic is_branch;
  logic stretch;
  logic next_cycle0;
  logic [15:0] instr_word_reg;

  decode_if dec_bus ();

  instr_decode u_decode (
    .bus(dec_bus)
  );

  // Decoder looks at the held instruction word
  assign instr_word_reg = state_reg.instr_word;
  assign dec_bus.instr_word = instr_word_reg;
  assign dec_bus.cond_codes = cond_codes;

  // Derived timing terms
  always_comb
  begin
    is_branch = state_reg.cycle0 && (state_reg.op_class == seq_pkg::OC_BRANCH);
    // C waits for memory once its minimum is spent
    if (state_reg.phase == seq_pkg::PH_C)
    begin
      phase_done = (state_reg.cnt >= STRETCH_LAST) && mem_ref_done; // RULE3
    end
    else
    begin
      phase_done = (state_reg.cnt == PHASE_LAST); // RULE1
    end
    // A branch's first cycle stretches only when taken
    if (is_branch)
    begin
      stretch = state_reg.taken; // RULE7 RULE8
    end
    else
    begin
      stretch = ustretch_req || cache_read_miss; // RULE2
    end
    // Spare class runs on under microcode, so only single and branch hand over at once
    next_cycle0 = (state_reg.cycle0 && ((state_reg.op_class == seq_pkg::OC_SINGLE) || is_branch)) ||
      ucode_instr_end; // RULE5
  end

  // Next-state logic for the whole sequencer
  always_comb
  begin
    state_next = state_reg;
    state_next.abort = 1'b0;
    if (!phase_done)
    begin
      state_next.cnt = (state_reg.cnt == 2'h3) ? state_reg.cnt : 2'(state_reg.cnt + 2'h1);
    end
    else
    begin
      state_next.cnt = 2'h0;
      unique case (state_reg.phase)
        seq_pkg::PH_A:
        begin
          state_next.phase = seq_pkg::PH_B; // RULE1
          // Latch decode at the end of A so ALU fields come from flops
          if (state_reg.cycle0)
          begin
            state_next.op_class = dec_bus.op_class; // RULE4
            state_next.alu_op = dec_bus.alu_op;
            state_next.src = dec_bus.src_reg;
            state_next.dst = dec_bus.dst_reg;
            state_next.disp = dec_bus.disp;
            state_next.taken = dec_bus.branch_taken; // RULE6
          end
        end
        seq_pkg::PH_B:
        begin
          if (stretch)
          begin
            state_next.phase = seq_pkg::PH_C; // RULE2
            state_next.abort = is_branch && state_reg.taken; // RULE7
          end
          else
          begin
            state_next.phase = seq_pkg::PH_A; // RULE8
          end
        end
        seq_pkg::PH_C:
        begin
          state_next.phase = seq_pkg::PH_A; // RULE3
        end
        default:
        begin
          state_next.phase = seq_pkg::PH_A;
        end
      endcase
      // New instruction word enters as its first cycle begins
      if (cycle_end)
      begin
        state_next.cycle0 = next_cycle0;
        if (next_cycle0)
        begin
          state_next.instr_word = fetch_word;
          state_next.op_class = seq_pkg::OC_MICRO;
          state_next.taken = 1'b0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg.phase <= seq_pkg::PH_A; // RULE9
      state_reg.cnt <= 2'h0;
      state_reg.cycle0 <= 1'b1;
      state_reg.instr_word <= `INSTR_RESET;
      state_reg.op_class <= seq_pkg::OC_MICRO;
      state_reg.alu_op <= `ALU_OP_ADD;
      state_reg.src <= 3'h0;
      state_reg.dst <= 3'h0;
      state_reg.disp <= 8'h00;
      state_reg.taken <= 1'b0;
      state_reg.abort <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs; ALU fields are held flops, strobes decode the phase
  always_comb
  begin
    phase_a = (state_reg.phase == seq_pkg::PH_A);
    phase_b = (state_reg.phase == seq_pkg::PH_B);
    phase_c = (state_reg.phase == seq_pkg::PH_C);
    cycle_end = phase_done && (phase_c || (phase_b && !stretch));
    cycle0 = state_reg.cycle0;
    alu_go = state_reg.cycle0 && phase_b && ((state_reg.op_class == seq_pkg::OC_SINGLE) || is_branch); // RULE5 RULE6
    alu_write_en = alu_go && !(is_branch && !state_reg.taken); // RULE8
    ucode_hold = state_reg.cycle0 && !phase_a && (state_reg.op_class == seq_pkg::OC_SINGLE); // RULE5
    prefetch_abort = state_reg.abort; // RULE7
    pc_load = phase_c && is_branch && state_reg.taken && phase_done; // RULE7
    alu_op = state_reg.alu_op;
    alu_src_reg = state_reg.src;
    alu_dst_reg = state_reg.dst;
    branch_disp = state_reg.disp;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence taken_branch_b_s;
    alu_go && is_branch && state_reg.taken;
  endsequence

  sequence abort_then_load_s;
    prefetch_abort && phase_c ##[0:20] pc_load;
  endsequence

  // Phase A always gives way to B after one cycle
  phase_a_to_b_a: assert property (phase_a |=> phase_b) // RULE1
    else $error("phase A not followed by phase B");

  phase_b_once_a: assert property (phase_b |=> !phase_b) // RULE1
    else $error("phase B lasted more than one cycle");

  stretch_enter_a: assert property (phase_b && !is_branch && (ustretch_req || cache_read_miss) |=> phase_c) // RULE2
    else $error("stretch request did not enter phase C");

  stretch_plain_a: assert property (phase_b && !is_branch && !ustretch_req && !cache_read_miss |=> phase_a) // RULE2
    else $error("phase C entered without cause");

  stretch_wait_a: assert property (phase_c && !mem_ref_done |=> phase_c) // RULE3
    else $error("phase C ended before memory completed");

  stretch_done_a: assert property (phase_c && mem_ref_done |=> phase_a && $past(phase_c)) // RULE3
    else $error("phase C not closed on memory completion");

  decode_latch_a: assert property (cycle0 && phase_a |=> alu_op == $past(dec_bus.alu_op)) // RULE4
    else $error("ALU opcode not taken from instruction word");

  single_next_a: assert property (alu_go && state_reg.op_class == seq_pkg::OC_SINGLE && !ustretch_req
    && !cache_read_miss |-> ucode_hold ##1 (phase_a && cycle0)) // RULE5
    else $error("single-cycle op did not start next instruction");

  branch_add_a: assert property (alu_go && is_branch |-> alu_op == `ALU_OP_ADD && alu_dst_reg == `REG_PC) // RULE6
    else $error("branch did not add into PC");

  taken_abort_a: assert property (taken_branch_b_s |=> abort_then_load_s) // RULE7
    else $error("taken branch did not abort prefetch and load PC in C");

  not_taken_a: assert property (alu_go && is_branch && !state_reg.taken |-> !alu_write_en ##1 phase_a) // RULE8
    else $error("not-taken branch wrote back or stretched");

  reset_state_a: assert property (disable iff (1'b0) !rst_n |=> phase_a && cycle0 && !prefetch_abort) // RULE9
    else $error("sequencer not idle in phase A after reset");

endmodule

`default_nettype wire

// ---- verilog/decode_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface decode_if;
  logic [15:0] instr_word;
  logic [3:0] cond_codes;
  seq_pkg::op_class_e op_class;
  logic [3:0] alu_op;
  logic [2:0] src_reg;
  logic [2:0] dst_reg;
  logic [7:0] disp;
  logic branch_taken;

  modport dec (
    input instr_word,
    input cond_codes,
    output op_class,
    output alu_op,
    output src_reg,
    output dst_reg,
    output disp,
    output branch_taken
  );

  modport seq (
    output instr_word,
    output cond_codes,
    input op_class,
    input alu_op,
    input src_reg,
    input dst_reg,
    input disp,
    input branch_taken
  );
endinterface

`default_nettype wire

// ---- verilog/instr_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "seq_regs.svh"

module instr_decode (
  decode_if.dec bus
);

  logic [1:0] cls;
  logic [1:0] sel;

  // Class, registers and ALU opcode straight from the instruction word
  always_comb
  begin
    cls = bus.instr_word[`INSTR_CLASS_HI:`INSTR_CLASS_LO];
    sel = bus.instr_word[`INSTR_BR_SEL_HI:`INSTR_BR_SEL_LO];
    bus.op_class = seq_pkg::op_class_e'(cls); // RULE4
    bus.src_reg = bus.instr_word[`INSTR_SRC_HI:`INSTR_SRC_LO];
    bus.dst_reg = bus.instr_word[`INSTR_DST_HI:`INSTR_DST_LO];
    bus.disp = bus.instr_word[`INSTR_DISP_HI:`INSTR_DISP_LO];
    bus.alu_op = bus.instr_word[`INSTR_ALUOP_HI:`INSTR_ALUOP_LO];
    // Branches add PC and displacement, whatever the opcode bits say
    if (bus.op_class == seq_pkg::OC_BRANCH)
    begin
      bus.alu_op = `ALU_OP_ADD; // RULE6
      bus.src_reg = `REG_PC;
      bus.dst_reg = `REG_PC;
    end
    // Separate condition check, evaluated in parallel with the add
    bus.branch_taken = bus.instr_word[`INSTR_BR_ALWAYS] |
      (bus.cond_codes[sel] ^ bus.instr_word[`INSTR_BR_INVERT]); // RULE6
  end

endmodule

`default_nettype wire

// ---- verilog/seq_pkg.sv ----
package seq_pkg;

  typedef enum logic [1:0] {
    PH_A = 2'b00,
    PH_B = 2'b01,
    PH_C = 2'b10
  } phase_e;

  typedef enum logic [1:0] {
    OC_MICRO = 2'b00,
    OC_SINGLE = 2'b01,
    OC_BRANCH = 2'b10,
    OC_SPARE = 2'b11
  } op_class_e;

  typedef struct packed {
    phase_e phase;
    logic [1:0] cnt;
    logic cycle0;
    logic [15:0] instr_word;
    op_class_e op_class;
    logic [3:0] alu_op;
    logic [2:0] src;
    logic [2:0] dst;
    logic [7:0] disp;
    logic taken;
    logic abort;
  } seq_state_s;

endpackage

// ---- verilog/seq_regs.svh ----
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

// Clock and phase timing
`define SEQ_CLK_PERIOD_NS 100
`define SEQ_PHASE_NS 50
`define SEQ_STRETCH_MIN_NS 50
// Least times round up, never below one cycle
`define SEQ_PHASE_CYC (((`SEQ_PHASE_NS + `SEQ_CLK_PERIOD_NS - 1) / `SEQ_CLK_PERIOD_NS) < 1 ? 1 : \
  ((`SEQ_PHASE_NS + `SEQ_CLK_PERIOD_NS - 1) / `SEQ_CLK_PERIOD_NS))
`define SEQ_STRETCH_MIN_CYC (((`SEQ_STRETCH_MIN_NS + `SEQ_CLK_PERIOD_NS - 1) / `SEQ_CLK_PERIOD_NS) < 1 ? 1 : \
  ((`SEQ_STRETCH_MIN_NS + `SEQ_CLK_PERIOD_NS - 1) / `SEQ_CLK_PERIOD_NS))

// Instruction word fields
`define INSTR_CLASS_HI 15
`define INSTR_CLASS_LO 14
`define INSTR_ALUOP_HI 13
`define INSTR_ALUOP_LO 10
`define INSTR_BR_ALWAYS 13
`define INSTR_BR_INVERT 12
`define INSTR_BR_SEL_HI 11
`define INSTR_BR_SEL_LO 10
`define INSTR_SRC_HI 5
`define INSTR_SRC_LO 3
`define INSTR_DST_HI 2
`define INSTR_DST_LO 0
`define INSTR_DISP_HI 7
`define INSTR_DISP_LO 0

// Fixed values
`define ALU_OP_ADD 4'h0
`define INSTR_RESET 16'h0000
`define REG_PC 3'h7

`endif
